// ==== inc/cafm_cfg.svh ====
// Register map, field positions and reset values of the acceptance filter bank.
`ifndef CAFM_CFG_SVH
`define CAFM_CFG_SVH

// ==========================================================================
// Sizes
// ==========================================================================
`define CAFM_NUM_FILT 16
`define CAFM_ADDR_W 8

// ==========================================================================
// Register offsets
// ==========================================================================
`define CAFM_OFS_FILT_BASE 8'h00
`define CAFM_OFS_MASK_SID 8'h80
`define CAFM_OFS_MASK_EID 8'h84
`define CAFM_OFS_FILT_EN 8'h88
`define CAFM_OFS_HIT_STAT 8'h8C

// ==========================================================================
// Field positions in the standard identifier register
// ==========================================================================
`define CAFM_SID_MSB 15
`define CAFM_SID_LSB 5
`define CAFM_TYPE_BIT 3
`define CAFM_EXTHI_MSB 1
`define CAFM_EXTHI_LSB 0
`define CAFM_SID_IMPL 16'hFFEB

// ==========================================================================
// Reset values
// ==========================================================================
`define CAFM_FILT_EN_RST 16'h0000
`define CAFM_HIT_RST 16'h0000

`endif

// ==== inc/cafm_pkg.sv ====
// Types shared by the acceptance filter bank.
package cafm_pkg;

    typedef logic [15:0] cafm_word_t;

    typedef enum logic [1:0] {
        CAFM_RESP_OKAY = 2'h0,
        CAFM_RESP_SLVERR = 2'h2
    } cafm_resp_t;

endpackage

// ==== rtl/cafm_filter_bank.sv ====
// Sixteen-entry CAN acceptance filter bank with an AXI4-Lite register slave.
//
// Contract
// - Sixteen independent filters, each with a standard and an extended register.
// - Standard identifier sits in bits 15..5; each compared bit must equal.
// - Extended bits 17..16 sit in bits 1..0 and must equal the message.
// - With type matching on, bit 3 selects extended (1) or standard (0) only.
// - With type matching off, the type-select bit is ignored.
// - Extended bits 15..0 fill the second register and must each equal.
// - Bits 4 and 2 of the standard register read zero; writes ignored.
// - Filter bits are not reset; software writes each filter before use.
// - Only positions whose mask bit is 1 are compared; others are don't-care.
`timescale 1ns/1ns
`default_nettype none
`include "cafm_cfg.svh"

module cafm_filter_bank (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // AXI4-Lite slave.
    input wire logic [`CAFM_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [`CAFM_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Received identifiers from the receive path.
    input wire logic rx_id_valid,
    input wire logic [10:0] rx_std_id,
    input wire logic [17:0] rx_ext_id,
    input wire logic rx_is_ext,
    // Match result.
    output logic [`CAFM_NUM_FILT-1:0] hit_vec,
    output logic hit_valid
);

    // ======================================================================
    // Storage
    // ======================================================================
    cafm_pkg::cafm_word_t filt_sid_reg [0:`CAFM_NUM_FILT-1];
    cafm_pkg::cafm_word_t filt_eid_reg [0:`CAFM_NUM_FILT-1];
    cafm_pkg::cafm_word_t mask_sid_reg;
    cafm_pkg::cafm_word_t mask_eid_reg;
    cafm_pkg::cafm_word_t filt_en_reg;
    cafm_pkg::cafm_word_t hit_stat_reg;

    logic aw_held_reg;
    logic w_held_reg;
    logic [`CAFM_ADDR_W-1:0] aw_addr_reg;
    logic [15:0] w_data_reg;
    logic [1:0] w_strb_reg;
    logic awready_reg;
    logic wready_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic arready_reg;
    logic rvalid_reg;
    logic [1:0] rresp_reg;
    logic [31:0] rdata_reg;
    logic [`CAFM_NUM_FILT-1:0] hit_vec_reg;
    logic hit_valid_reg;

    // ======================================================================
    // Write channel handshake
    // ======================================================================
    wire aw_take;
    wire w_take;
    wire do_write;
    wire aw_held_next;
    wire w_held_next;
    wire bvalid_next;
    wire awready_next;
    wire wready_next;

    assign aw_take = s_axi_awvalid & awready_reg;
    assign w_take = s_axi_wvalid & wready_reg;
    assign do_write = aw_held_reg & w_held_reg & ~bvalid_reg;
    assign aw_held_next = (aw_held_reg | aw_take) & ~do_write;
    assign w_held_next = (w_held_reg | w_take) & ~do_write;
    assign bvalid_next = do_write | (bvalid_reg & ~s_axi_bready);
    assign awready_next = ~aw_held_next & ~bvalid_next;
    assign wready_next = ~w_held_next & ~bvalid_next;

    // ======================================================================
    // Write decode
    // ======================================================================
    wire [15:0] byte_en;
    wire wr_filt_area;
    wire [3:0] wr_idx;
    wire wr_is_eid;
    wire wr_mask_sid;
    wire wr_mask_eid;
    wire wr_filt_en;
    wire wr_hit_stat;
    wire wr_hit;

    assign byte_en = {{8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};
    assign wr_filt_area = (aw_addr_reg[7] == 1'b0) & (aw_addr_reg[1:0] == 2'h0);
    assign wr_idx = aw_addr_reg[6:3];
    assign wr_is_eid = aw_addr_reg[2];
    assign wr_mask_sid = aw_addr_reg == `CAFM_OFS_MASK_SID;
    assign wr_mask_eid = aw_addr_reg == `CAFM_OFS_MASK_EID;
    assign wr_filt_en = aw_addr_reg == `CAFM_OFS_FILT_EN;
    assign wr_hit_stat = aw_addr_reg == `CAFM_OFS_HIT_STAT;
    assign wr_hit = wr_filt_area | wr_mask_sid | wr_mask_eid | wr_filt_en | wr_hit_stat;

    function automatic cafm_pkg::cafm_word_t merge(input cafm_pkg::cafm_word_t old_v,
                                                  input cafm_pkg::cafm_word_t new_v,
                                                  input cafm_pkg::cafm_word_t en);
        merge = (old_v & ~en) | (new_v & en);
    endfunction

    // ======================================================================
    // Filter entries and comparators
    // ======================================================================
    wire [`CAFM_NUM_FILT-1:0] hit_raw;

    genvar gi;
    generate
        for (gi = 0; gi < `CAFM_NUM_FILT; gi = gi + 1) begin : g_filt
            wire sel;
            assign sel = ce & do_write & wr_filt_area & (wr_idx == 4'(gi));
            // No reset: the contents are undefined until software loads them.
            always_ff @(posedge clk) begin
                if (sel & ~wr_is_eid) begin
                    filt_sid_reg[gi] <= merge(filt_sid_reg[gi], w_data_reg, byte_en)
                        & `CAFM_SID_IMPL;
                end
                if (sel & wr_is_eid) begin
                    filt_eid_reg[gi] <= merge(filt_eid_reg[gi], w_data_reg, byte_en);
                end
            end
            cafm_filter_cmp u_cmp (
                .filt_sid(filt_sid_reg[gi]),
                .filt_eid(filt_eid_reg[gi]),
                .mask_sid(mask_sid_reg),
                .mask_eid(mask_eid_reg),
                .rx_std_id(rx_std_id),
                .rx_ext_id(rx_ext_id),
                .rx_is_ext(rx_is_ext),
                .hit(hit_raw[gi])
            );
        end
    endgenerate

    // Mask registers are unreset like the filters they qualify.
    always_ff @(posedge clk) begin
        if (ce & do_write & wr_mask_sid) begin
            mask_sid_reg <= merge(mask_sid_reg, w_data_reg, byte_en) & `CAFM_SID_IMPL;
        end
        if (ce & do_write & wr_mask_eid) begin
            mask_eid_reg <= merge(mask_eid_reg, w_data_reg, byte_en);
        end
    end

    // ======================================================================
    // Read decode
    // ======================================================================
    wire [3:0] rd_idx;
    wire rd_filt_area;
    wire rd_hit;
    wire [15:0] rd_word;

    assign rd_idx = s_axi_araddr[6:3];
    assign rd_filt_area = (s_axi_araddr[7] == 1'b0) & (s_axi_araddr[1:0] == 2'h0);
    assign rd_hit = rd_filt_area
        | (s_axi_araddr == `CAFM_OFS_MASK_SID) | (s_axi_araddr == `CAFM_OFS_MASK_EID)
        | (s_axi_araddr == `CAFM_OFS_FILT_EN) | (s_axi_araddr == `CAFM_OFS_HIT_STAT);
    assign rd_word = rd_filt_area ? (s_axi_araddr[2] ? filt_eid_reg[rd_idx]
                                                     : filt_sid_reg[rd_idx])
        : (s_axi_araddr == `CAFM_OFS_MASK_SID) ? mask_sid_reg
        : (s_axi_araddr == `CAFM_OFS_MASK_EID) ? mask_eid_reg
        : (s_axi_araddr == `CAFM_OFS_FILT_EN) ? filt_en_reg
        : (s_axi_araddr == `CAFM_OFS_HIT_STAT) ? hit_stat_reg
        : 16'h0000;

    wire ar_take;
    wire rvalid_next;

    assign ar_take = s_axi_arvalid & arready_reg;
    assign rvalid_next = ar_take | (rvalid_reg & ~s_axi_rready);

    // ======================================================================
    // Match result
    // ======================================================================
    wire [`CAFM_NUM_FILT-1:0] hit_gated;

    assign hit_gated = hit_raw & filt_en_reg;

    wire [`CAFM_NUM_FILT-1:0] hit_set;
    wire [`CAFM_NUM_FILT-1:0] hit_clr;

    assign hit_set = rx_id_valid ? hit_gated : 16'h0000;
    assign hit_clr = (do_write & wr_hit_stat) ? (w_data_reg & byte_en) : 16'h0000;

    // ======================================================================
    // Control registers
    // ======================================================================
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            aw_addr_reg <= 8'h00;
            w_data_reg <= 16'h0000;
            w_strb_reg <= 2'h0;
            awready_reg <= 1'b0;
            wready_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            bresp_reg <= cafm_pkg::CAFM_RESP_OKAY;
        end else if (ce) begin
            aw_held_reg <= aw_held_next;
            w_held_reg <= w_held_next;
            awready_reg <= awready_next;
            wready_reg <= wready_next;
            bvalid_reg <= bvalid_next;
            if (aw_take) begin
                aw_addr_reg <= s_axi_awaddr;
            end
            if (w_take) begin
                w_data_reg <= s_axi_wdata[15:0];
                w_strb_reg <= s_axi_wstrb[1:0];
            end
            if (do_write) begin
                bresp_reg <= wr_hit ? cafm_pkg::CAFM_RESP_OKAY : cafm_pkg::CAFM_RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b0;
            rresp_reg <= cafm_pkg::CAFM_RESP_OKAY;
            rdata_reg <= 32'h0000_0000;
        end else if (ce) begin
            arready_reg <= ~rvalid_next;
            rvalid_reg <= rvalid_next;
            if (ar_take) begin
                rdata_reg <= {16'h0000, rd_word};
                rresp_reg <= rd_hit ? cafm_pkg::CAFM_RESP_OKAY : cafm_pkg::CAFM_RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            filt_en_reg <= `CAFM_FILT_EN_RST;
            hit_stat_reg <= `CAFM_HIT_RST;
            hit_vec_reg <= `CAFM_HIT_RST;
            hit_valid_reg <= 1'b0;
        end else if (ce) begin
            hit_valid_reg <= rx_id_valid;
            if (rx_id_valid) begin
                hit_vec_reg <= hit_gated;
            end
            if (do_write & wr_filt_en) begin
                filt_en_reg <= merge(filt_en_reg, w_data_reg, byte_en);
            end
            // A hit on a bit wins over a software clear of that bit in the same cycle.
            hit_stat_reg <= (hit_stat_reg & ~hit_clr) | hit_set;
        end
    end

    // ======================================================================
    // Outputs
    // ======================================================================
    assign s_axi_awready = awready_reg;
    assign s_axi_wready = wready_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_arready = arready_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rresp = rresp_reg;
    assign s_axi_rdata = rdata_reg;
    assign hit_vec = hit_vec_reg;
    assign hit_valid = hit_valid_reg;

endmodule
`default_nettype wire

// ==== rtl/cafm_filter_cmp.sv ====
// Identifier comparison of one acceptance filter against a received identifier.
`timescale 1ns/1ns
`default_nettype none
`include "cafm_cfg.svh"

module cafm_filter_cmp (
    input wire logic [15:0] filt_sid,
    input wire logic [15:0] filt_eid,
    input wire logic [15:0] mask_sid,
    input wire logic [15:0] mask_eid,
    input wire logic [10:0] rx_std_id,
    input wire logic [17:0] rx_ext_id,
    input wire logic rx_is_ext,
    output logic hit
);

    wire [10:0] std_diff;
    wire [17:0] ext_diff;
    wire [10:0] std_care;
    wire [17:0] ext_care;
    wire std_ok;
    wire ext_ok;
    wire type_ok;

    assign std_diff = rx_std_id ^ filt_sid[`CAFM_SID_MSB:`CAFM_SID_LSB];
    assign ext_diff = rx_ext_id
        ^ {filt_sid[`CAFM_EXTHI_MSB:`CAFM_EXTHI_LSB], filt_eid};
    assign std_care = mask_sid[`CAFM_SID_MSB:`CAFM_SID_LSB];
    assign ext_care = {mask_sid[`CAFM_EXTHI_MSB:`CAFM_EXTHI_LSB], mask_eid};
    assign std_ok = ~|(std_diff & std_care);
    // Extended bits only exist in extended frames, so standard frames skip them.
    assign ext_ok = ~rx_is_ext | ~|(ext_diff & ext_care);
    // The type bit counts only when the mask enables type matching.
    assign type_ok = ~mask_sid[`CAFM_TYPE_BIT]
        | (filt_sid[`CAFM_TYPE_BIT] == rx_is_ext);
    assign hit = std_ok & ext_ok & type_ok;

endmodule
`default_nettype wire

// ==== verif/cafm_filter_bank_props.sv ====
// Concurrent checks on the ports of the acceptance filter bank.
`timescale 1ns/1ns
`default_nettype none
module cafm_filter_bank_props (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic rx_id_valid,
    input wire logic [15:0] hit_vec,
    input wire logic hit_valid
);
    // ====================
    // Helper state
    // ====================
    logic sid_rd_reg;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sid_rd_reg <= 1'h0;
        end else if (s_axi_arvalid && s_axi_arready && ce) begin
            sid_rd_reg <= (s_axi_araddr[2:0] == 3'h0) && (s_axi_araddr <= 8'h80);
        end
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    // ====================
    // Assertions
    // ====================
    hit_latency_a: assert property ((rx_id_valid && ce) |=> hit_valid)
        else $error("hit_valid missing after identifier");
    hit_cause_a: assert property ((ce && !rx_id_valid) |=> !hit_valid)
        else $error("hit_valid without identifier");
    hit_hold_a: assert property (!(rx_id_valid && ce) |=> $stable(hit_vec))
        else $error("hit_vec changed without identifier");
    sid_unimpl_a: assert property (
        (s_axi_rvalid && sid_rd_reg) |-> !s_axi_rdata[4] && !s_axi_rdata[2])
        else $error("unimplemented standard register bit reads one");
    rd_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
        else $error("read data upper half not zero");
    resp_hold_a: assert property (
        (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    rdata_hold_a: assert property (
        (s_axi_rvalid && !s_axi_rready) |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    wr_answer_a: assert property (
        (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && ce)
        |-> ##[1:2] s_axi_bvalid)
        else $error("write response late");
    unmapped_rd_a: assert property (
        (s_axi_arvalid && s_axi_arready && s_axi_araddr >= 8'h90)
        |-> ##[1:2] (s_axi_rvalid && s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0))
        else $error("unmapped read not refused");
    freeze_hold_a: assert property (
        !ce |=> $stable({s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready,
        s_axi_rvalid, hit_valid, hit_vec}))
        else $error("state moved while clock enable low");
    hit_seen_c: cover property (hit_valid && hit_vec != 16'h0000);
    back_to_back_c: cover property (rx_id_valid ##1 rx_id_valid);
    slverr_c: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule
bind cafm_filter_bank cafm_filter_bank_props cafm_filter_bank_props_inst (.clk, .rst_n, .ce,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .rx_id_valid, .hit_vec, .hit_valid);
`default_nettype wire

// ==== verif/cafm_filter_bank_tb.sv ====
// Self-checking testbench of the acceptance filter bank.
`timescale 1ns/1ns
`default_nettype none
module cafm_filter_bank_tb;
    logic clk = 1'h0;
    logic rst_n = 1'h0;
    logic ce = 1'h1;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, r;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic rx_id_valid, rx_is_ext, hit_valid, ex;
    logic [10:0] rx_std_id, sd;
    logic [17:0] rx_ext_id, ed;
    logic [15:0] hit_vec, msid, meid, en, hs = 16'h0000;
    logic [15:0] fs[16], fe[16];
    logic [33:0] rsp_q[$];
    logic [15:0] hit_q[$];
    logic [31:0] seed = 32'h44;
    int error_cnt = 0, check_count = 0, cyc = 0;
    always #10 clk = ~clk;
    cafm_filter_bank cafm_filter_bank_inst (.clk, .rst_n, .ce, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rx_id_valid, .rx_std_id,
        .rx_ext_id, .rx_is_ext, .hit_vec, .hit_valid);
    cafm_rx_src cafm_rx_src_inst (.clk, .rx_id_valid, .rx_std_id, .rx_ext_id, .rx_is_ext);
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [15:0] exp_hits(logic [10:0] s, logic [17:0] e, logic x);
        logic [15:0] h;
        for (int i = 0; i < 16; i++) begin
            h[i] = en[i] && (((s ^ fs[i][15:5]) & msid[15:5]) == 11'h000)
                && (!x || (((e ^ {fs[i][1:0], fe[i]}) & {msid[1:0], meid}) == 18'h00000))
                && (!msid[3] || (fs[i][3] == x));
        end
        return h;
    endfunction
    task automatic check(string nm, logic [33:0] exp, logic [33:0] got);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("FAIL %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic report_and_stop();
        if (error_cnt == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic wr(logic [7:0] a, logic [15:0] d, logic [1:0] rs);
        logic [31:0] u;
        logic aw_done;
        logic w_done;
        logic b_done;
        u = rnd();
        aw_done = 1'h0;
        w_done = 1'h0;
        b_done = 1'h0;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {u[31:16], d};
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        rsp_q.push_back({rs, 32'h0});
        // Local flags, since the valid and ready lines read back their old value in this time step.
        while (!b_done) begin
            @(posedge clk);
            if (!aw_done && s_axi_awready) begin
                s_axi_awvalid <= 1'h0;
                aw_done = 1'h1;
            end
            if (!w_done && s_axi_wready) begin
                s_axi_wvalid <= 1'h0;
                w_done = 1'h1;
            end
            if (s_axi_bvalid) begin
                s_axi_bready <= 1'h0;
                b_done = 1'h1;
            end
        end
    endtask
    task automatic rd(logic [7:0] a, logic [33:0] exp);
        logic ar_done;
        logic r_done;
        ar_done = 1'h0;
        r_done = 1'h0;
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        rsp_q.push_back(exp);
        while (!r_done) begin
            @(posedge clk);
            if (!ar_done && s_axi_arready) begin
                s_axi_arvalid <= 1'h0;
                ar_done = 1'h1;
            end
            if (s_axi_rvalid) begin
                s_axi_rready <= 1'h0;
                r_done = 1'h1;
            end
        end
    endtask
    // Results are taken off the queues in the order they were launched.
    always @(posedge clk) begin
        if (s_axi_bvalid === 1'h1 && s_axi_bready === 1'h1) begin
            check("bresp", rsp_q.pop_front(), {s_axi_bresp, 32'h0});
        end
        if (s_axi_rvalid === 1'h1 && s_axi_rready === 1'h1) begin
            check("rdata", rsp_q.pop_front(), {s_axi_rresp, s_axi_rdata});
        end
        if (hit_valid === 1'h1) begin
            check("hit_vec", {18'h0, hit_q.pop_front()}, {18'h0, hit_vec});
        end
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            report_and_stop();
        end
    end
    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'h1;
        rd(8'h88, {2'h0, 32'h0});
        rd(8'h90, {2'h2, 32'h0});
        wr(8'h06, 16'hFFFF, 2'h2);
        for (int m = 0; m < 3; m++) begin
            for (int i = 0; i < 16; i++) begin
                fs[i] = 16'(rnd()) & 16'hFFEB;
                fe[i] = 16'(rnd());
                wr(8'(8 * i), fs[i] | 16'h0014, 2'h0);
                wr(8'(8 * i + 4), fe[i], 2'h0);
                if (i == 0) begin
                    s_axi_wstrb <= 4'hE;
                    wr(8'h04, ~fe[0], 2'h0);
                    fe[0][15:8] = ~fe[0][15:8];
                    s_axi_wstrb <= 4'hF;
                end
                rd(8'(8 * i), {18'h0, fs[i]});
                rd(8'(8 * i + 4), {18'h0, fe[i]});
            end
            msid = (m == 2) ? (16'(rnd()) & 16'hFFEB) : ((m == 1) ? 16'hFFE3 : 16'hFFEB);
            meid = (m == 2) ? 16'(rnd()) : 16'hFFFF;
            en = (m == 1) ? 16'(rnd()) : 16'hFFFF;
            wr(8'h80, msid, 2'h0);
            wr(8'h84, meid, 2'h0);
            wr(8'h88, en, 2'h0);
            for (int k = 0; k < 48; k++) begin
                r = rnd();
                sd = (k < 32) ? fs[k % 16][15:5] : r[10:0];
                ed = (k < 32) ? {fs[k % 16][1:0], fe[k % 16]} : r[28:11];
                ex = (k < 16) ? fs[k % 16][3] : ((k < 32) ? !fs[k % 16][3] : r[31]);
                hit_q.push_back(exp_hits(sd, ed, ex));
                hs = hs | hit_q[$];
                cafm_rx_src_inst.send(sd, ed, ex);
            end
            cafm_rx_src_inst.idle();
            repeat (3) @(posedge clk);
            rd(8'h8C, {18'h0, hs});
            wr(8'h8C, 16'hFFFF, 2'h0);
            hs = 16'h0000;
            rd(8'h8C, {18'h0, hs});
            // Freeze the block for a few idle cycles; the checker watches its outputs.
            ce <= 1'h0;
            repeat (3) @(posedge clk);
            ce <= 1'h1;
        end
        check("pending", 34'h0, 34'(hit_q.size() + rsp_q.size()));
        report_and_stop();
    end
endmodule
`default_nettype wire

// ==== verif/cafm_rx_src.sv ====
// Receive-path model that presents identifiers to the filter bank.
`timescale 1ns/1ns
`default_nettype none
module cafm_rx_src (
    input wire logic clk,
    output logic rx_id_valid,
    output logic [10:0] rx_std_id,
    output logic [17:0] rx_ext_id,
    output logic rx_is_ext
);
    initial begin
        rx_id_valid = 1'h0;
        rx_std_id = 11'h000;
        rx_ext_id = 18'h00000;
        rx_is_ext = 1'h0;
    end
    task automatic send(logic [10:0] sd, logic [17:0] ed, logic ex);
        @(posedge clk);
        rx_id_valid <= 1'h1;
        rx_std_id <= sd;
        rx_ext_id <= ed;
        rx_is_ext <= ex;
    endtask
    // Between frames the identifier lines mean nothing, so they are scrambled.
    task automatic idle();
        @(posedge clk);
        rx_id_valid <= 1'h0;
        rx_std_id <= ~rx_std_id;
        rx_ext_id <= ~rx_ext_id;
        rx_is_ext <= ~rx_is_ext;
    endtask
endmodule
`default_nettype wire
